// [rmc_params.svh]
// constants of the radio modem configuration register bank
`ifndef RMC_PARAMS_SVH
`define RMC_PARAMS_SVH

// bus geometry: byte address is four times the register index
`define RMC_AW 14
`define RMC_IDX_W 12
`define RMC_DW 32

// register indices
`define RMC_IDX_PA_LEVEL 12'h307
`define RMC_IDX_WAKE_HIGH 12'h30C
`define RMC_IDX_WAKE_LOW 12'h30D
`define RMC_IDX_SIG_STRENGTH 12'h312
`define RMC_IDX_IMAGE_CAL 12'h319
`define RMC_IDX_LOOP_DIV 12'h32F
`define RMC_IDX_PKT_SRC 12'h336
`define RMC_IDX_CMD_SRC 12'h337
`define RMC_IDX_CAL_CTRL 12'h338
`define RMC_IDX_CAL_STAT 12'h339
`define RMC_IDX_CAL_WORD 12'h345
`define RMC_IDX_CAL_OVR 12'h346
`define RMC_IDX_LOOP_MODE 12'h35D

// field positions
`define RMC_WAKE_MEM_BIT 3
`define RMC_IMG_OVR_BIT 5
`define RMC_PKT_TX_BIT 4
`define RMC_PKT_ADDR_BIT 3
`define RMC_PKT_CRC_BIT 2
`define RMC_PKT_SYNC_BIT 1
`define RMC_PKT_PRE_BIT 0
`define RMC_CMD_READY_BIT 6
`define RMC_CMD_PORT_BIT 1
`define RMC_CMD_DONE_BIT 0
`define RMC_CAL_SYNTH_BIT 1
`define RMC_CAL_FILT_BIT 0

// implemented bits of the event source registers
`define RMC_PKT_MASK 8'h1F
`define RMC_CMD_MASK 8'h43

// reset values
`define RMC_RST_ZERO 8'h00
`define RMC_RST_LOOP_DIV 8'h28

// calibration source decodes
`define RMC_DIV_OFF 5'h00
`define RMC_DIV_4 5'h04
`define RMC_DIV_8 5'h08
`define RMC_DIV_16 5'h10
`define RMC_PWR_X0 3'h0
`define RMC_PWR_X1 3'h1
`define RMC_PWR_X2 3'h2
`define RMC_PWR_X3 3'h3
`define RMC_PWR_X4 3'h4

// signal strength offset in dBm, applied by software
`define RMC_SIG_OFFSET_DBM 107

// bus responses
`define RMC_RESP_OKAY 2'h0
`define RMC_RESP_SLVERR 2'h2

`endif

// [rmc_pkg.sv]
// types of the radio modem configuration register bank
package rmc_pkg;

  typedef enum logic [1:0] {
    RMC_LOOP_FREE = 2'h0,
    RMC_LOOP_MANUAL = 2'h1,
    RMC_LOOP_HOLD = 2'h2,
    RMC_LOOP_LOCK = 2'h3
  } rmc_loop_op_t;

  typedef struct packed {
    logic [2:0] stg;
    logic level;
  } rmc_sync_st_t;

  typedef struct packed {
    logic [7:0] flags;
  } rmc_sticky_st_t;

  typedef struct packed {
    logic aw_got;
    logic [11:0] aw_idx;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [5:0] pa_level;
    logic mem_power;
    logic mem_power_hold;
    logic [7:0] sig_strength;
    logic [5:0] image_cal;
    logic [7:0] loop_div;
    logic [1:0] cal_ctrl;
    logic [6:0] cal_ovr;
    logic [6:0] loop_mode;
    logic [4:0] src_div;
    logic [2:0] src_pwr;
    logic [5:0] cal_word;
    logic [1:0] amp_gain;
    logic mix_gain;
    logic [1:0] filt_gain;
  } rmc_top_st_t;

endpackage

// [rmc_sync.sv]
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
`include "rmc_params.svh"
module rmc_sync (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // asynchronous level in, filtered level out
  input wire logic i_async,
  output logic o_level
);
  rmc_pkg::rmc_sync_st_t q;
  rmc_pkg::rmc_sync_st_t d;

  // stage 0 feeds stage 1 only; the filter looks at stages 1 and 2
  always_comb
  begin
    d = q;
    d.stg = {q.stg[1:0], i_async};
    if (q.stg[1] == q.stg[2])
    begin
      d.level = q.stg[2];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_level = q.level;
endmodule // rmc_sync

// [rmc_sticky.sv]
// sticky event flags, write one to clear, set beats clear
`timescale 1ns/100ps
`include "rmc_params.svh"
module rmc_sticky #(
  parameter logic [7:0] MASK = 8'hFF
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // events, software clear mask, content loss
  input wire logic [7:0] i_set,
  input wire logic [7:0] i_clr,
  input wire logic i_wipe,
  output logic [7:0] o_flags
);
  rmc_pkg::rmc_sticky_st_t q;
  rmc_pkg::rmc_sticky_st_t d;

  always_comb
  begin
    d = q;
    d.flags = ((q.flags & ~i_clr) | i_set) & MASK;
    if (i_wipe)
    begin
      d.flags = `RMC_RST_ZERO;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_flags = q.flags;
endmodule // rmc_sticky

// [rmc_top.sv]
// radio modem configuration register bank behind an axi4-lite slave
`timescale 1ns/100ps
`include "rmc_params.svh"
module rmc_top (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // axi4-lite write address and data
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [13:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // axi4-lite write response
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // axi4-lite read
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [13:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // radio state, asynchronous
  input wire logic i_radio_sleep_state,
  // radio events, one-cycle pulses, and the packet mode level
  input wire logic i_packet_mode,
  input wire logic i_ev_tx_done,
  input wire logic i_ev_addr_match,
  input wire logic i_ev_crc_ok,
  input wire logic i_ev_sync_found,
  input wire logic i_ev_preamble_found,
  input wire logic i_ev_cmd_ready,
  input wire logic i_ev_cmd_done,
  input wire logic i_ev_port_ready,
  // radio status
  input wire logic i_rx_packet_done,
  input wire logic [7:0] i_sig_strength,
  input wire logic i_synth_calibration_done,
  input wire logic i_rx_filter_calibration_done,
  input wire logic i_amp_ramp_done,
  input wire logic [5:0] i_filter_cal_result,
  input wire logic [1:0] i_loop_amp_gain,
  input wire logic i_loop_mix_gain,
  input wire logic [1:0] i_loop_filt_gain,
  // configuration to the radio
  output logic [5:0] o_pa_target_level,
  output logic o_sleep_memory_power_enable,
  output logic o_image_cal_override_enable,
  output logic [4:0] o_cal_src_divide,
  output logic [2:0] o_cal_src_power,
  output logic [7:0] o_gain_loop_clock_divide,
  output logic o_synth_calibration_enable,
  output logic o_rx_filter_calibration_enable,
  output logic [5:0] o_filter_cal_word,
  output logic [1:0] o_gain_loop_operation,
  output logic [1:0] o_low_noise_amp_gain,
  output logic o_mixer_gain,
  output logic [1:0] o_filter_gain
);
  rmc_pkg::rmc_top_st_t q;
  rmc_pkg::rmc_top_st_t d;
  logic sleep_lvl;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic commit;
  logic wr_en;
  logic [11:0] wr_idx;
  logic [11:0] rd_idx;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic [7:0] rd_byte;
  logic [7:0] pkt_flags;
  logic [7:0] cmd_flags;
  logic [7:0] pkt_set;
  logic [7:0] cmd_set;
  logic [7:0] pkt_clr;
  logic [7:0] cmd_clr;
  function automatic logic is_mapped(input logic [11:0] idx);
    case (idx)
      `RMC_IDX_PA_LEVEL, `RMC_IDX_WAKE_HIGH, `RMC_IDX_WAKE_LOW,
      `RMC_IDX_SIG_STRENGTH, `RMC_IDX_IMAGE_CAL, `RMC_IDX_LOOP_DIV,
      `RMC_IDX_PKT_SRC, `RMC_IDX_CMD_SRC, `RMC_IDX_CAL_CTRL,
      `RMC_IDX_CAL_STAT, `RMC_IDX_CAL_WORD, `RMC_IDX_CAL_OVR,
      `RMC_IDX_LOOP_MODE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction
  function automatic logic [4:0] src_divisor(input logic [1:0] sel);
    case (sel)
      2'h1: src_divisor = `RMC_DIV_4;
      2'h2: src_divisor = `RMC_DIV_8;
      2'h3: src_divisor = `RMC_DIV_16;
      default: src_divisor = `RMC_DIV_OFF;
    endcase
  endfunction
  function automatic logic [2:0] src_power(input logic [2:0] sel);
    case (sel)
      3'h1, 3'h2: src_power = `RMC_PWR_X1;
      3'h3, 3'h4: src_power = `RMC_PWR_X2;
      3'h5, 3'h6: src_power = `RMC_PWR_X3;
      3'h7: src_power = `RMC_PWR_X4;
      default: src_power = `RMC_PWR_X0;
    endcase
  endfunction
  // sleep arrives from the power controller, outside this clock
  rmc_sync u_sleep_sync (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(i_radio_sleep_state),
    .o_level(sleep_lvl)
  );
  always_comb
  begin
    pkt_set = `RMC_RST_ZERO;
    pkt_set[`RMC_PKT_TX_BIT] = i_ev_tx_done && i_packet_mode;
    pkt_set[`RMC_PKT_ADDR_BIT] = i_ev_addr_match && i_packet_mode;
    pkt_set[`RMC_PKT_CRC_BIT] = i_ev_crc_ok && i_packet_mode;
    pkt_set[`RMC_PKT_SYNC_BIT] = i_ev_sync_found;
    pkt_set[`RMC_PKT_PRE_BIT] = i_ev_preamble_found;
    cmd_set = `RMC_RST_ZERO;
    cmd_set[`RMC_CMD_READY_BIT] = i_ev_cmd_ready;
    cmd_set[`RMC_CMD_DONE_BIT] = i_ev_cmd_done;
    cmd_set[`RMC_CMD_PORT_BIT] = i_ev_port_ready;
  end
  assign pkt_clr = (wr_en && wr_idx == `RMC_IDX_PKT_SRC) ?
    wr_byte : `RMC_RST_ZERO;
  assign cmd_clr = (wr_en && wr_idx == `RMC_IDX_CMD_SRC) ?
    wr_byte : `RMC_RST_ZERO;
  // an event in the clearing cycle survives the clear
  rmc_sticky #(.MASK(`RMC_PKT_MASK)) u_pkt_src (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_set(pkt_set),
    .i_clr(pkt_clr), .i_wipe(sleep_lvl), .o_flags(pkt_flags)
  );
  rmc_sticky #(.MASK(`RMC_CMD_MASK)) u_cmd_src (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_set(cmd_set),
    .i_clr(cmd_clr), .i_wipe(sleep_lvl), .o_flags(cmd_flags)
  );
  assign o_s_axi_awready = !q.aw_got && !q.bvalid;
  assign o_s_axi_wready = !q.w_got && !q.bvalid;
  assign o_s_axi_arready = !q.rvalid;
  assign aw_hs = i_s_axi_awvalid && o_s_axi_awready;
  assign w_hs = i_s_axi_wvalid && o_s_axi_wready;
  assign ar_hs = i_s_axi_arvalid && o_s_axi_arready;
  assign wr_idx = q.aw_got ? q.aw_idx : i_s_axi_awaddr[13:2];
  assign wr_byte = q.w_got ? q.w_data : i_s_axi_wdata[7:0];
  assign wr_lane = q.w_got ? q.w_lane : i_s_axi_wstrb[0];
  assign rd_idx = i_s_axi_araddr[13:2];
  assign commit = (q.aw_got || aw_hs) && (q.w_got || w_hs);
  // writes during sleep are answered but discarded
  assign wr_en = commit && wr_lane && !sleep_lvl;
  always_comb
  begin
    d = q;
    case (rd_idx)
      `RMC_IDX_PA_LEVEL: rd_byte = {2'h0, q.pa_level};
      `RMC_IDX_SIG_STRENGTH: rd_byte = q.sig_strength;
      `RMC_IDX_IMAGE_CAL: rd_byte = {2'h0, q.image_cal};
      `RMC_IDX_LOOP_DIV: rd_byte = q.loop_div;
      `RMC_IDX_PKT_SRC: rd_byte = pkt_flags;
      `RMC_IDX_CMD_SRC: rd_byte = cmd_flags;
      `RMC_IDX_CAL_CTRL: rd_byte = {6'h00, q.cal_ctrl};
      `RMC_IDX_CAL_STAT: rd_byte = {5'h00, i_amp_ramp_done,
        i_synth_calibration_done,
        i_rx_filter_calibration_done && q.cal_ctrl[`RMC_CAL_FILT_BIT]};
      `RMC_IDX_CAL_WORD: rd_byte = {2'h0, q.cal_word};
      `RMC_IDX_CAL_OVR: rd_byte = {1'h0, q.cal_ovr};
      `RMC_IDX_LOOP_MODE: rd_byte = {1'h0, q.loop_mode};
      default: rd_byte = `RMC_RST_ZERO;
    endcase
    if (aw_hs && !commit)
    begin
      d.aw_got = 1'b1;
      d.aw_idx = i_s_axi_awaddr[13:2];
    end
    if (w_hs && !commit)
    begin
      d.w_got = 1'b1;
      d.w_data = i_s_axi_wdata[7:0];
      d.w_lane = i_s_axi_wstrb[0];
    end
    if (commit)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = is_mapped(wr_idx) ? `RMC_RESP_OKAY : `RMC_RESP_SLVERR;
    end
    else if (q.bvalid && i_s_axi_bready)
    begin
      d.bvalid = 1'b0;
    end
    if (ar_hs)
    begin
      d.rvalid = 1'b1;
      d.rdata = {24'h00_0000, rd_byte};
      d.rresp = is_mapped(rd_idx) ? `RMC_RESP_OKAY : `RMC_RESP_SLVERR;
    end
    else if (q.rvalid && i_s_axi_rready)
    begin
      d.rvalid = 1'b0;
    end
    if (wr_en)
    begin
      case (wr_idx)
        `RMC_IDX_PA_LEVEL: d.pa_level = wr_byte[5:0];
        `RMC_IDX_WAKE_LOW: d.mem_power = wr_byte[`RMC_WAKE_MEM_BIT];
        `RMC_IDX_IMAGE_CAL: d.image_cal = wr_byte[5:0];
        `RMC_IDX_LOOP_DIV: d.loop_div = wr_byte;
        `RMC_IDX_CAL_CTRL: d.cal_ctrl = wr_byte[1:0];
        `RMC_IDX_CAL_OVR: d.cal_ovr = wr_byte[6:0];
        `RMC_IDX_LOOP_MODE: d.loop_mode = wr_byte[6:0];
      endcase
    end
    if (i_rx_packet_done)
    begin
      d.sig_strength = i_sig_strength;
    end
    // memory power must survive the wipe, so it is held while asleep
    if (!sleep_lvl)
    begin
      d.mem_power_hold = d.mem_power;
    end
    if (sleep_lvl)
    begin
      d.pa_level = 6'h00;
      d.mem_power = 1'b0;
      d.sig_strength = `RMC_RST_ZERO;
      d.image_cal = 6'h00;
      d.loop_div = `RMC_RST_LOOP_DIV;
      d.cal_ctrl = 2'h0;
      d.cal_ovr = 7'h00;
      d.loop_mode = 7'h00;
    end
    d.src_div = src_divisor(d.image_cal[4:3]);
    d.src_pwr = src_power(d.image_cal[2:0]);
    d.cal_word = d.cal_ovr[0] ? d.cal_ovr[6:1] : i_filter_cal_result;
    if (d.loop_mode[6:5] == rmc_pkg::RMC_LOOP_MANUAL)
    begin
      d.amp_gain = d.loop_mode[4:3];
      d.mix_gain = d.loop_mode[2];
      d.filt_gain = d.loop_mode[1:0];
    end
    else
    begin
      d.amp_gain = i_loop_amp_gain;
      d.mix_gain = i_loop_mix_gain;
      d.filt_gain = i_loop_filt_gain;
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      q <= '0;
      q.loop_div <= `RMC_RST_LOOP_DIV;
    end
    else
    begin
      q <= d;
    end
  end
  assign o_s_axi_bvalid = q.bvalid;
  assign o_s_axi_bresp = q.bresp;
  assign o_s_axi_rvalid = q.rvalid;
  assign o_s_axi_rdata = q.rdata;
  assign o_s_axi_rresp = q.rresp;
  assign o_pa_target_level = q.pa_level;
  assign o_sleep_memory_power_enable = q.mem_power_hold;
  assign o_image_cal_override_enable = q.image_cal[`RMC_IMG_OVR_BIT];
  assign o_cal_src_divide = q.src_div;
  assign o_cal_src_power = q.src_pwr;
  assign o_gain_loop_clock_divide = q.loop_div;
  assign o_synth_calibration_enable = q.cal_ctrl[`RMC_CAL_SYNTH_BIT];
  assign o_rx_filter_calibration_enable = q.cal_ctrl[`RMC_CAL_FILT_BIT];
  assign o_filter_cal_word = q.cal_word;
  assign o_gain_loop_operation = q.loop_mode[6:5];
  assign o_low_noise_amp_gain = q.amp_gain;
  assign o_mixer_gain = q.mix_gain;
  assign o_filter_gain = q.filt_gain;
  chk_sleep_wipe: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) sleep_lvl |=> (q.pa_level == 6'h00 &&
    o_gain_loop_clock_divide == `RMC_RST_LOOP_DIV && pkt_flags ==
    `RMC_RST_ZERO)) else $error("bank not wiped in sleep");
  chk_pa_write: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) (wr_en && wr_idx == `RMC_IDX_PA_LEVEL) |=>
    ({2'h0, o_pa_target_level} == ($past(wr_byte) & 8'h3F)))
    else $error("amplifier level write lost");
  chk_mem_hold: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) (sleep_lvl && $past(sleep_lvl)) |->
    $stable(o_sleep_memory_power_enable))
    else $error("memory power changed in sleep");
  chk_strength_take: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) (i_rx_packet_done && !sleep_lvl) |=>
    q.sig_strength == $past(i_sig_strength))
    else $error("signal strength not captured");
  chk_src_decode: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) (q.image_cal[4:3] == 2'h3) |->
    (o_cal_src_divide == `RMC_DIV_16))
    else $error("source divide decode wrong");
  chk_src_power: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) (q.image_cal[2:0] == 3'h7) |->
    (o_cal_src_power == `RMC_PWR_X4))
    else $error("source power decode wrong");
  chk_tx_event: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) (i_ev_tx_done && i_packet_mode && !sleep_lvl)
    |=> pkt_flags[`RMC_PKT_TX_BIT])
    else $error("transmit end not flagged");
  chk_tx_gated: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) (i_ev_tx_done && !i_packet_mode &&
    !pkt_flags[`RMC_PKT_TX_BIT]) |=> !pkt_flags[`RMC_PKT_TX_BIT])
    else $error("transmit end flagged outside packet mode");
  chk_cmd_event: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) (i_ev_cmd_ready && !sleep_lvl) |=>
    cmd_flags[`RMC_CMD_READY_BIT])
    else $error("command ready not flagged");
  chk_filt_gate: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) (ar_hs && rd_idx == `RMC_IDX_CAL_STAT &&
    !q.cal_ctrl[`RMC_CAL_FILT_BIT]) |=> !o_s_axi_rdata[0])
    else $error("filter done shown while disabled");
  chk_ovr_word: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) q.cal_ovr[0] |->
    (o_filter_cal_word == q.cal_ovr[6:1]))
    else $error("override word not applied");
  chk_manual_gain: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) (q.loop_mode[6:5] == rmc_pkg::RMC_LOOP_MANUAL) |->
    (o_low_noise_amp_gain == q.loop_mode[4:3] &&
    o_mixer_gain == q.loop_mode[2] && o_filter_gain == q.loop_mode[1:0]))
    else $error("manual gains not applied");
  chk_write_resp: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    commit |=> o_s_axi_bvalid [*1] ##0 (o_s_axi_bresp ==
    $past(is_mapped(wr_idx) ? `RMC_RESP_OKAY : `RMC_RESP_SLVERR)))
    else $error("write response missing");
endmodule // rmc_top

// [rmc_host_model.sv]
// host partner: axi4-lite master with bounded register accesses
`timescale 1ns/100ps
module rmc_host_model (
  // clock
  input wire logic i_clk_sys,
  // write channels
  output logic o_awvalid,
  output logic [13:0] o_awaddr,
  input wire logic i_awready,
  output logic o_wvalid,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  input wire logic i_wready,
  input wire logic i_bvalid,
  input wire logic [1:0] i_bresp,
  output logic o_bready,
  // read channels
  output logic o_arvalid,
  output logic [13:0] o_araddr,
  input wire logic i_arready,
  input wire logic i_rvalid,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp,
  output logic o_rready
);
  initial
  begin
    {o_awvalid, o_awaddr, o_wvalid, o_wdata, o_bready} = '0;
    {o_arvalid, o_araddr, o_rready} = '0;
    o_wstrb = 4'hF;
  end
  // payload is inverted on release so stale values never look valid
  task automatic acc(input logic w, input logic [11:0] i,
    input logic [7:0] d, output logic [31:0] q, output logic [1:0] r,
    output logic t);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    if (w)
    begin
      {o_awvalid, o_wvalid, o_bready} <= 3'h7;
      o_awaddr <= {i, 2'h0};
      o_wdata <= {24'h00_0000, d};
    end
    else
    begin
      {o_arvalid, o_rready} <= 2'h3;
      o_araddr <= {i, 2'h0};
    end
    do
    begin
      @(posedge i_clk_sys);
      n++;
      if (o_awvalid && i_awready)
        {o_awvalid, o_awaddr} <= {1'b0, ~o_awaddr};
      if (o_wvalid && i_wready)
        {o_wvalid, o_wdata} <= {1'b0, ~o_wdata};
      if (o_arvalid && i_arready)
        {o_arvalid, o_araddr} <= {1'b0, ~o_araddr};
    end while (!(w ? i_bvalid : i_rvalid) && n < 200);
    {q, r, t} = {i_rdata, w ? i_bresp : i_rresp, n >= 200};
    {o_bready, o_rready} <= 2'h0;
  endtask
endmodule // rmc_host_model

// [rmc_top_tb.sv]
// self-checking bench for the modem configuration register bank
`timescale 1ns/100ps
`include "rmc_params.svh"
module rmc_top_tb;
  typedef struct packed {
    logic [11:0] idx;
    logic [7:0] din;
    logic [7:0] dout;
    logic [1:0] rsp;
  } rmc_row_t;
  localparam logic [1:0] OK = `RMC_RESP_OKAY;
  localparam logic [1:0] SE = `RMC_RESP_SLVERR;
  localparam rmc_row_t ROWS [15] = '{
    '{`RMC_IDX_PA_LEVEL, 8'h3F, 8'h3F, OK},
    '{`RMC_IDX_WAKE_HIGH, 8'h00, 8'h00, OK},
    '{`RMC_IDX_WAKE_LOW, 8'h00, 8'h00, OK},
    '{`RMC_IDX_SIG_STRENGTH, 8'hAA, 8'h00, OK},
    '{`RMC_IDX_IMAGE_CAL, 8'h3F, 8'h3F, OK},
    '{`RMC_IDX_LOOP_DIV, 8'hA5, 8'hA5, OK},
    '{`RMC_IDX_PKT_SRC, 8'h00, 8'h00, OK},
    '{`RMC_IDX_CMD_SRC, 8'h00, 8'h00, OK},
    '{`RMC_IDX_CAL_CTRL, 8'h03, 8'h03, OK},
    '{`RMC_IDX_CAL_STAT, 8'h00, 8'h00, OK},
    '{`RMC_IDX_CAL_OVR, 8'h7F, 8'h7F, OK},
    '{`RMC_IDX_CAL_WORD, 8'h00, 8'h3F, OK},
    '{`RMC_IDX_LOOP_MODE, 8'h7F, 8'h7F, OK},
    '{12'h300, 8'h5A, 8'h00, SE},
    '{12'hFFF, 8'h5A, 8'h00, SE}
  };
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [13:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic [1:0] bs, rs;
  logic sleep = 1'b0;
  logic pkt_mode = 1'b0;
  logic pkt_done = 1'b0;
  logic [4:0] pev = 5'h00;
  logic [2:0] cev = 3'h0;
  logic [7:0] sig = 8'h00;
  logic [2:0] stat = 3'h0;
  logic [5:0] cal_res = 6'h00;
  logic [4:0] lgain = 5'h1A;
  logic [5:0] pa, cword;
  logic [4:0] sdiv;
  logic [2:0] spwr;
  logic [7:0] ldiv;
  logic [1:0] lop, lna, fg;
  logic memp, imgov, sen, fen, mg;
  int n_mismatch = 0;
  int tests_run = 0;
  always #4 i_clk_sys = ~i_clk_sys;
  rmc_top rmc_top_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(ws), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
    .o_s_axi_bresp(bs), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr),
    .o_s_axi_rdata(rd), .o_s_axi_rresp(rs), .i_radio_sleep_state(sleep),
    .i_packet_mode(pkt_mode), .i_ev_tx_done(pev[4]),
    .i_ev_addr_match(pev[3]), .i_ev_crc_ok(pev[2]),
    .i_ev_sync_found(pev[1]), .i_ev_preamble_found(pev[0]),
    .i_ev_cmd_ready(cev[2]), .i_ev_cmd_done(cev[0]),
    .i_ev_port_ready(cev[1]), .i_rx_packet_done(pkt_done),
    .i_sig_strength(sig), .i_synth_calibration_done(stat[1]),
    .i_rx_filter_calibration_done(stat[0]), .i_amp_ramp_done(stat[2]),
    .i_filter_cal_result(cal_res), .i_loop_amp_gain(lgain[4:3]),
    .i_loop_mix_gain(lgain[2]), .i_loop_filt_gain(lgain[1:0]),
    .o_pa_target_level(pa), .o_sleep_memory_power_enable(memp),
    .o_image_cal_override_enable(imgov), .o_cal_src_divide(sdiv),
    .o_cal_src_power(spwr), .o_gain_loop_clock_divide(ldiv),
    .o_synth_calibration_enable(sen),
    .o_rx_filter_calibration_enable(fen), .o_filter_cal_word(cword),
    .o_gain_loop_operation(lop), .o_low_noise_amp_gain(lna),
    .o_mixer_gain(mg), .o_filter_gain(fg)
  );
  rmc_host_model rmc_host_model_i (
    .i_clk_sys(i_clk_sys), .o_awvalid(awv), .o_awaddr(awa),
    .i_awready(awr), .o_wvalid(wv), .o_wdata(wd), .o_wstrb(ws),
    .i_wready(wr), .i_bvalid(bv), .i_bresp(bs), .o_bready(br),
    .o_arvalid(arv), .o_araddr(ara), .i_arready(arr), .i_rvalid(rv),
    .i_rdata(rd), .i_rresp(rs), .o_rready(rr)
  );
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    $display("compares=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [11:0] i,
    input logic [7:0] d, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    logic t;
    rmc_host_model_i.acc(w, i, d, q, r, t);
    if (t)
    begin
      n_mismatch++;
      wrap_up();
    end
    if (!w)
      chk(q, e);
    chk(32'(r), 32'(er));
  endtask
  task automatic wc(input logic [11:0] i, input logic [7:0] d,
    input logic [1:0] er = OK);
    acc(1'b1, i, d, 32'h0, er);
  endtask
  task automatic rc(input logic [11:0] i, input logic [31:0] e,
    input logic [1:0] er = OK);
    acc(1'b0, i, 8'h00, e, er);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic pulse(input logic [4:0] p, input logic [2:0] c,
    input logic d);
    @(posedge i_clk_sys);
    {pev, cev, pkt_done} <= {p, c, d};
    @(posedge i_clk_sys);
    {pev, cev, pkt_done} <= 9'h000;
  endtask
  // every place reads its reset value, including the live status
  task automatic rst_check;
    foreach (ROWS[k])
      rc(ROWS[k].idx, ROWS[k].idx == `RMC_IDX_LOOP_DIV ?
        32'(`RMC_RST_LOOP_DIV) : 32'h0, ROWS[k].rsp);
  endtask
  initial
  begin
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rst_check();
    chk(32'({pa, cword, lop, memp}), 32'h0);
    foreach (ROWS[k])
    begin
      wc(ROWS[k].idx, ROWS[k].din, ROWS[k].rsp);
      rc(ROWS[k].idx, 32'(ROWS[k].dout), ROWS[k].rsp);
    end
    chk(32'({pa, sen, fen}), 32'h0FF);
    for (int f = 0; f < 4; f++)
      for (int p = 0; p < 8; p++)
      begin
        wc(`RMC_IDX_IMAGE_CAL, 8'(p % 2 * 32 + f * 8 + p));
        cyc(3);
        chk(32'(sdiv), 32'(f == 0 ? 0 : 2 << f));
        chk(32'(spwr), 32'((p + 1) / 2));
        chk(32'(imgov), 32'(p % 2));
      end
    for (int op = 0; op < 4; op++)
    begin
      wc(`RMC_IDX_LOOP_MODE, 8'(op * 32 + 13));
      cyc(3);
      chk(32'(lop), 32'(op));
      chk(32'({lna, mg, fg}), 32'(op == 1 ? 5'h0D : 5'h1A));
    end
    cal_res <= 6'h15;
    wc(`RMC_IDX_CAL_OVR, 8'h00);
    cyc(3);
    rc(`RMC_IDX_CAL_WORD, 32'h15);
    wc(`RMC_IDX_CAL_OVR, 8'h55);
    cyc(3);
    rc(`RMC_IDX_CAL_WORD, 32'h2A);
    chk(32'(cword), 32'h2A);
    stat <= 3'h5;
    cyc(3);
    rc(`RMC_IDX_CAL_STAT, 32'h5);
    wc(`RMC_IDX_CAL_CTRL, 8'h00);
    stat <= 3'h3;
    cyc(3);
    chk(32'({sen, fen}), 32'h0);
    rc(`RMC_IDX_CAL_STAT, 32'h2);
    // packet-only events must stay clear outside packet mode
    pulse(5'h1F, 3'h7, 1'b0);
    rc(`RMC_IDX_PKT_SRC, 32'h03);
    rc(`RMC_IDX_CMD_SRC, 32'h43);
    wc(`RMC_IDX_PKT_SRC, 8'h01);
    rc(`RMC_IDX_PKT_SRC, 32'h02);
    wc(`RMC_IDX_CMD_SRC, 8'h41);
    rc(`RMC_IDX_CMD_SRC, 32'h02);
    pkt_mode <= 1'b1;
    sig <= 8'h5A;
    pulse(5'h1F, 3'h0, 1'b1);
    rc(`RMC_IDX_PKT_SRC, 32'h1F);
    rc(`RMC_IDX_SIG_STRENGTH, 32'h5A);
    // event and its own clear land on one edge: the event must win
    fork
      wc(`RMC_IDX_PKT_SRC, 8'h01);
      pulse(5'h01, 3'h0, 1'b0);
    join
    rc(`RMC_IDX_PKT_SRC, 32'h1F);
    wc(`RMC_IDX_WAKE_HIGH, 8'h00);
    wc(`RMC_IDX_WAKE_LOW, 8'h08);
    cyc(3);
    chk(32'(memp), 32'h1);
    {stat, cal_res, sleep} <= 10'h001;
    cyc(8);
    wc(`RMC_IDX_PA_LEVEL, 8'h2A);
    chk(32'(memp), 32'h1);
    sleep <= 1'b0;
    cyc(8);
    rst_check();
    chk(32'({memp, pa}), 32'h0);
    wc(`RMC_IDX_LOOP_DIV, 8'h07);
    chk(32'(ldiv), 32'h07);
    i_rst <= 1'b1;
    cyc(2);
    chk(32'(ldiv), 32'(`RMC_RST_LOOP_DIV));
    i_rst <= 1'b0;
    rst_check();
    wrap_up();
  end
endmodule // rmc_top_tb
